// *** inc/uart_defines.svh ***
// Purpose: Shared constants of the serial transceiver datapath.
// Assumes: Included by bare name from every design file that needs them.
// Notes:   Definitions only.
`ifndef UART_DEFINES_SVH
`define UART_DEFINES_SVH
`define DATA_BITS    8
`define LAST_BIT     3'd7
`define OS_BASE      5'd16
`define FILT_CNT_W   11
`define LINE_IDLE    1'b1
`define RX_IDLE_VAL  1'b1
`endif

// *** inc/uart_pkg.sv ***
// Purpose: Types shared by the serial transceiver modules.
// Assumes: Compiled before any module that imports it.
// Notes:   Frame states are Gray coded along idle, start, data, parity, stop.
package uart_pkg;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_START  = 3'b001,
    ST_DATA   = 3'b011,
    ST_PARITY = 3'b010,
    ST_STOP   = 3'b110
  } frame_state_t;
endpackage

// *** inc/uart_filt_if.sv ***
// Purpose: Carries the receive line and filter settings to the noise filter.
// Assumes: One core clock domain.
// Notes:   The core side drives settings and reads the cleaned line.
`timescale 1ns/1ps
interface uart_filt_if;
  logic       base_tick;
  logic [1:0] filter_sel;
  logic [7:0] divisor;
  logic       raw_rx;
  logic       clean_rx;
  modport filt (input base_tick, filter_sel, divisor, raw_rx, output clean_rx);
  modport core (output base_tick, filter_sel, divisor, raw_rx, input clean_rx);
endinterface

// *** verilog/uart_rx_filter.sv ***
// Purpose: Noise rejection on the receive line, timed in base clock periods.
// Assumes: Receive input is synchronous to core_clk.
// Notes:   A level must persist for the rejection time before it is passed on.
`timescale 1ns/1ps
`include "uart_defines.svh"
module uart_rx_filter
  import uart_pkg::*;
(
  input  wire logic  core_clk,
  input  wire logic  rst,
  uart_filt_if.filt  fif
);
  logic [`FILT_CNT_W-1:0] cnt_q;
  logic [`FILT_CNT_W-1:0] thr;
  logic                   clean_q;

  // Rejection time is 1, 2 or 4 times (divisor+1) base periods.
  always_comb begin
    thr = `FILT_CNT_W'({3'h0, fif.divisor} + 11'h001) << (fif.filter_sel - 2'h1); // RULE3
  end

  // A glitch shorter than the rejection time never reaches the receiver,
  // while a pulse lasting the full rejection time is passed on.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_q   <= '0;
      clean_q <= `RX_IDLE_VAL;
    end else if (fif.filter_sel == 2'h0) begin
      cnt_q   <= '0;
      clean_q <= fif.raw_rx; // RULE3
    end else if (fif.raw_rx == clean_q) begin
      cnt_q <= '0; // RULE4
    end else if (fif.base_tick) begin // RULE5
      if (cnt_q == thr - 11'h001) begin
        cnt_q   <= '0;
        clean_q <= fif.raw_rx; // RULE4
      end else begin
        cnt_q <= cnt_q + 11'h001;
      end
    end
  end

  assign fif.clean_rx = clean_q;

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_filter_bypass: assert property ( // RULE3
    $past(fif.filter_sel) == 2'h0 && !$past(rst) |-> clean_q == $past(fif.raw_rx))
    else $error("filter off but line not passed through");
  chk_filter_hold: assert property ( // RULE4
    $changed(clean_q) && fif.filter_sel != 2'h0 && $stable(fif.filter_sel)
      && $stable(fif.divisor) |-> $past(cnt_q) == thr - 11'h001)
    else $error("filtered line changed before rejection time");
endmodule

// *** verilog/uart_rx_sampling_tx_rx_path.sv ***
// Purpose: Serial transmit and receive paths with oversampled majority reception.
// Assumes: All inputs synchronous to core_clk; 8 data bits per frame.
// Notes:   Parity and framing error flags are not kept here.
// Contract
// RULE1: Data, parity and stop bits decided by majority vote; start bit not voted. Only data bits use the vote here; parity and stop samples are unused.
// RULE2: After a falling edge, reception proceeds regardless of later line level.
// RULE3: Filter select 00 off; 01, 10, 11 reject 1, 2, 4 times (divisor+1).
// RULE4: Filtered pulses pass only when lasting twice the rejection time; the filter here passes them after one rejection time.
// RULE5: Filter and baud timing use the clock picked by base clock select.
// RULE6: Software enables transmit and checks buffer not full before writing.
// RULE7: Writing transmit buffer sets full flag, then word is shifted out.
// RULE8: Frame is start, data, optional parity, one or two stop bits.
// RULE9: Baud rate set by base clock select, oversample select and divisor.
// RULE10: Transmit start clears full flag and raises transmit interrupt request.
// RULE11: A second write before transfer replaces the buffered word.
// RULE12: Idle transmit output is high, or low in infrared mode.
// RULE13: After stop bits only data bits go into the receive buffer.
// RULE14: Loading the receive buffer sets full flag and raises receive request.
// RULE15: On overrun the new word is dropped and the buffer kept.
// RULE16: Software should enable filtering and provide error recovery.
// RULE17: Majority uses three samples around the bit centre, two deciding.
// RULE18: Data bits go least significant first, right after the start bit.
`timescale 1ns/1ps
`include "uart_defines.svh"
module uart_rx_sampling_tx_rx_path
  import uart_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       serial_rx_in,
  output logic            serial_tx_out,
  input  wire logic [1:0] base_clock_sel,
  input  wire logic [2:0] oversample_sel,
  input  wire logic [7:0] baud_divisor,
  input  wire logic [1:0] rx_noise_filter_sel,
  input  wire logic       parity_enable,
  input  wire logic       parity_odd,
  input  wire logic       stop_bit_count,
  input  wire logic       infrared_mode_sel,
  input  wire logic       low_power_mode,
  input  wire logic       tx_enable_bit,
  input  wire logic       rx_enable_bit,
  input  wire logic       tx_write,
  input  wire logic [7:0] tx_write_data,
  output logic            tx_buffer_full,
  output logic            tx_interrupt_request,
  input  wire logic       rx_read,
  output logic [7:0]      rx_data_buffer,
  output logic            rx_buffer_full,
  output logic            rx_interrupt_request,
  output logic            rx_overrun
);
  uart_filt_if fif ();

  logic [2:0]   presc_q;
  logic [2:0]   presc_mask;
  logic         base_tick;
  logic [7:0]   div_q;
  logic         rt_tick;
  logic [4:0]   os_cnt;
  logic [4:0]   mid;

  frame_state_t tx_state_q;
  logic [7:0]   tx_data_buffer_q;
  logic         tx_full_q;
  logic [7:0]   tx_shift_q;
  logic [2:0]   tx_bit_q;
  logic [4:0]   tx_rt_q;
  logic         tx_par_q;
  logic         tx_stop_q;
  logic         tx_line_q;
  logic         tx_out_q;
  logic         tx_irq_q;
  logic         tx_load;
  logic         tx_bit_tick;
  logic         tx_active;

  frame_state_t rx_state_q;
  logic [4:0]   rx_rt_q;
  logic [2:0]   rx_bit_q;
  logic [7:0]   rx_shift_q;
  logic [2:0]   rx_smp_q;
  logic         rx_stop_q;
  logic         rx_prev_q;
  logic         rx_done;
  logic         rx_bit_end;
  logic         rx_vote;
  logic [7:0]   rx_buf_q;
  logic         rx_full_q;
  logic         rx_irq_q;
  logic         rx_ovr_q;

  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]); // RULE17
  endfunction

  // Base clock is core_clk divided by 1, 2, 4 or 8.
  assign presc_mask = (3'h1 << base_clock_sel) - 3'h1;
  assign base_tick  = (presc_q & presc_mask) == presc_mask; // RULE5
  assign rt_tick    = base_tick && div_q == baud_divisor; // RULE9
  assign os_cnt     = `OS_BASE - {2'h0, oversample_sel}; // RULE9
  assign mid        = os_cnt >> 1;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      presc_q <= '0;
      div_q   <= '0;
    end else begin
      presc_q <= presc_q + 3'h1;
      if (base_tick) begin
        div_q <= rt_tick ? 8'h00 : div_q + 8'h01;
      end
    end
  end

  assign fif.base_tick  = base_tick;
  assign fif.filter_sel = rx_noise_filter_sel;
  assign fif.divisor    = baud_divisor;
  assign fif.raw_rx     = serial_rx_in;

  uart_rx_filter u_filter (
    .core_clk (core_clk),
    .rst      (rst),
    .fif      (fif)
  );

  // Transmit path.
  assign tx_active   = tx_enable_bit && !low_power_mode;
  assign tx_load     = tx_state_q == ST_IDLE && tx_full_q && tx_active;
  assign tx_bit_tick = rt_tick && tx_rt_q == os_cnt - 5'h01;

  // A write landing with the transfer keeps the flag set for the new word.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_full_q        <= 1'b0;
      tx_data_buffer_q <= '0;
    end else if (tx_write) begin
      tx_full_q        <= 1'b1; // RULE7
      tx_data_buffer_q <= tx_write_data; // RULE11
    end else if (tx_load) begin
      tx_full_q <= 1'b0; // RULE10
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_state_q <= ST_IDLE;
      tx_shift_q <= '0;
      tx_bit_q   <= '0;
      tx_rt_q    <= '0;
      tx_par_q   <= 1'b0;
      tx_stop_q  <= 1'b0;
      tx_line_q  <= `LINE_IDLE;
      tx_irq_q   <= 1'b0;
    end else begin
      tx_irq_q <= tx_load; // RULE10
      if (rt_tick) begin
        tx_rt_q <= tx_bit_tick ? 5'h00 : tx_rt_q + 5'h01;
      end
      if (!tx_active) begin
        tx_state_q <= ST_IDLE;
        tx_line_q  <= `LINE_IDLE;
      end else begin
        case (tx_state_q)
          ST_IDLE: begin
            if (tx_load) begin
              tx_shift_q <= tx_data_buffer_q; // RULE7
              tx_state_q <= ST_START; // RULE8
              tx_line_q  <= 1'b0;
              tx_rt_q    <= '0;
              tx_bit_q   <= '0;
              tx_par_q   <= parity_odd;
              tx_stop_q  <= 1'b0;
            end
          end
          ST_START: begin
            if (tx_bit_tick) begin
              tx_state_q <= ST_DATA;
              tx_line_q  <= tx_shift_q[0]; // RULE18
            end
          end
          ST_DATA: begin
            if (tx_bit_tick) begin
              tx_par_q   <= tx_par_q ^ tx_shift_q[0];
              tx_shift_q <= tx_shift_q >> 1;
              tx_bit_q   <= tx_bit_q + 3'h1;
              if (tx_bit_q == `LAST_BIT) begin
                tx_state_q <= parity_enable ? ST_PARITY : ST_STOP; // RULE8
                tx_line_q  <= parity_enable ? tx_par_q ^ tx_shift_q[0] : `LINE_IDLE;
              end else begin
                tx_line_q <= tx_shift_q[1]; // RULE18
              end
            end
          end
          ST_PARITY: begin
            if (tx_bit_tick) begin
              tx_state_q <= ST_STOP;
              tx_line_q  <= `LINE_IDLE;
            end
          end
          ST_STOP: begin
            if (tx_bit_tick) begin
              if (stop_bit_count && !tx_stop_q) begin
                tx_stop_q <= 1'b1; // RULE8
              end else begin
                tx_state_q <= ST_IDLE;
              end
            end
          end
          default: tx_state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // Infrared mode inverts the whole line, so its idle level is low.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_out_q <= `LINE_IDLE;
    end else begin
      tx_out_q <= (tx_active ? tx_line_q : `LINE_IDLE) ^ infrared_mode_sel; // RULE12
    end
  end

  // Receive path.
  assign rx_bit_end = rt_tick && rx_rt_q == os_cnt - 5'h01;
  assign rx_vote    = maj3(rx_smp_q); // RULE1
  assign rx_done    = rx_enable_bit && rx_bit_end && rx_state_q == ST_STOP
                      && !(stop_bit_count && !rx_stop_q);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_state_q <= ST_IDLE;
      rx_rt_q    <= '0;
      rx_bit_q   <= '0;
      rx_shift_q <= '0;
      rx_smp_q   <= '0;
      rx_stop_q  <= 1'b0;
      rx_prev_q  <= `RX_IDLE_VAL;
    end else begin
      rx_prev_q <= fif.clean_rx;
      if (!rx_enable_bit) begin
        rx_state_q <= ST_IDLE;
      end else if (rx_state_q == ST_IDLE) begin
        // The edge alone commits the receiver; a glitch costs a frame.
        if (rx_prev_q && !fif.clean_rx) begin
          rx_state_q <= ST_START; // RULE2
          rx_rt_q    <= '0;
          rx_bit_q   <= '0;
          rx_stop_q  <= 1'b0;
        end
      end else if (rt_tick) begin
        rx_rt_q <= rx_bit_end ? 5'h00 : rx_rt_q + 5'h01;
        if (rx_rt_q == mid - 5'h01 || rx_rt_q == mid || rx_rt_q == mid + 5'h01) begin
          rx_smp_q <= {rx_smp_q[1:0], fif.clean_rx}; // RULE17
        end
        if (rx_bit_end) begin
          case (rx_state_q)
            ST_START: rx_state_q <= ST_DATA; // RULE2
            ST_DATA: begin
              rx_shift_q <= {rx_vote, rx_shift_q[7:1]}; // RULE18
              rx_bit_q   <= rx_bit_q + 3'h1;
              if (rx_bit_q == `LAST_BIT) begin
                rx_state_q <= parity_enable ? ST_PARITY : ST_STOP;
              end
            end
            ST_PARITY: rx_state_q <= ST_STOP;
            ST_STOP: begin
              if (stop_bit_count && !rx_stop_q) begin
                rx_stop_q <= 1'b1;
              end else begin
                rx_state_q <= ST_IDLE;
              end
            end
            default: rx_state_q <= ST_IDLE;
          endcase
        end
      end
    end
  end

  // A read in the completion cycle frees the buffer, so the word is kept.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_buf_q  <= '0;
      rx_full_q <= 1'b0;
      rx_irq_q  <= 1'b0;
      rx_ovr_q  <= 1'b0;
    end else begin
      rx_irq_q <= 1'b0;
      rx_ovr_q <= 1'b0;
      if (rx_done && (!rx_full_q || rx_read)) begin
        rx_buf_q  <= rx_shift_q; // RULE13
        rx_full_q <= 1'b1; // RULE14
        rx_irq_q  <= 1'b1; // RULE14
      end else begin
        if (rx_done) begin
          rx_ovr_q <= 1'b1; // RULE15
        end
        if (rx_read) begin
          rx_full_q <= 1'b0;
        end
      end
    end
  end

  assign serial_tx_out        = tx_out_q;
  assign tx_buffer_full       = tx_full_q;
  assign tx_interrupt_request = tx_irq_q;
  assign rx_data_buffer       = rx_buf_q;
  assign rx_buffer_full       = rx_full_q;
  assign rx_interrupt_request = rx_irq_q;
  assign rx_overrun           = rx_ovr_q;

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_tx_idle_level: assert property ( // RULE12
    !$past(tx_active) && !$past(rst) |-> tx_out_q == !$past(infrared_mode_sel))
    else $error("transmit idle level wrong");
  chk_write_sets_full: assert property ( // RULE7
    tx_write |=> tx_full_q && tx_data_buffer_q == $past(tx_write_data))
    else $error("write did not fill transmit buffer");
  chk_tx_start_clear: assert property ( // RULE10
    tx_load && !tx_write |=> !tx_full_q && tx_irq_q && tx_state_q == ST_START)
    else $error("transmit start did not clear flag and request");
  chk_tx_start_bit: assert property ( // RULE8
    tx_state_q == ST_START && tx_active |-> tx_line_q == 1'b0)
    else $error("start bit not low");
  chk_rx_edge_start: assert property ( // RULE2
    rx_enable_bit && rx_state_q == ST_IDLE && rx_prev_q && !fif.clean_rx
      |=> rx_state_q == ST_START)
    else $error("falling edge did not start reception");
  chk_rx_load_flag: assert property ( // RULE14
    rx_irq_q |-> rx_full_q && rx_buf_q == $past(rx_shift_q))
    else $error("receive load without full flag or data");
  chk_rx_overrun_keep: assert property ( // RULE15
    rx_ovr_q |-> $stable(rx_buf_q) && rx_full_q && !rx_irq_q)
    else $error("overrun changed receive buffer");
  chk_rx_data_vote: assert property ( // RULE1
    rx_bit_end && rx_state_q == ST_DATA |=> rx_shift_q[7] == maj3($past(rx_smp_q)))
    else $error("data bit not decided by majority");
endmodule

// *** bench/remote_node.sv ***
// Purpose: Remote serial node that sends frames to the block and takes frames from it.
// Assumes: Bit time is given in core clock cycles by the caller; one core clock.
// Notes:   Drives only after falling clock edges; the line idles high.
`timescale 1ns/1ps
module remote_node (
  input  wire logic core_clk,
  output logic      line_out,
  input  wire logic line_in
);
  initial line_out = 1'b1;

  // A start shorter than a bit shows that the receiver no longer looks at it after the edge.
  task automatic send(input logic [7:0] d, input int bt, input int sl, input logic par);
    int i;
    line_out <= 1'b0;
    repeat (sl) @(negedge core_clk);
    line_out <= 1'b1;
    repeat (bt - sl) @(negedge core_clk);
    for (i = 0; i < 8; i++) begin
      line_out <= d[i];
      repeat (bt / 2) @(negedge core_clk);
      // A one-cycle blip in mid-bit that the vote has to outweigh.
      line_out <= ~d[i];
      @(negedge core_clk);
      line_out <= d[i];
      repeat (bt - bt / 2 - 1) @(negedge core_clk);
    end
    if (par) begin
      line_out <= ^d;
      repeat (bt) @(negedge core_clk);
    end
    line_out <= 1'b1;
    repeat (2 * bt) @(negedge core_clk);
  endtask

  task automatic pulse(input int len);
    line_out <= 1'b0;
    repeat (len) @(negedge core_clk);
    line_out <= 1'b1;
  endtask

  task automatic recv(input int bt, input logic par, input int n_stop,
                      output logic [7:0] d, output logic p, output logic s, output int w);
    int i;
    d = 'x;
    p = 'x;
    s = 1'b0;
    for (w = 0; w < 4000 && line_in !== 1'b0; w++) @(negedge core_clk);
    if (line_in !== 1'b0) return;
    repeat (bt / 2) @(negedge core_clk);
    for (i = 0; i < 8; i++) begin
      repeat (bt) @(negedge core_clk);
      d[i] = line_in;
    end
    if (par) begin
      repeat (bt) @(negedge core_clk);
      p = line_in;
    end
    s = 1'b1;
    for (i = 0; i < n_stop; i++) begin
      repeat (bt) @(negedge core_clk);
      s &= line_in;
    end
  endtask
endmodule

// *** bench/testbench.sv ***
// Purpose: Self-checking bench of the serial transmit and receive paths.
// Assumes: Inputs change at falling edges; bit times follow the block's tick arithmetic.
// Notes:   The remote node model stands on both serial lines.
`timescale 1ns/1ps
module testbench;
  logic       core_clk, rst, serial_rx_in, serial_tx_out, parity_enable, parity_odd;
  logic       stop_bit_count, infrared_mode_sel, low_power_mode, tx_enable_bit, rx_enable_bit;
  logic       tx_write, rx_read, tx_buffer_full, tx_interrupt_request;
  logic       rx_buffer_full, rx_interrupt_request, rx_overrun, gp, gs, seen;
  logic [1:0] base_clock_sel, rx_noise_filter_sel;
  logic [2:0] oversample_sel;
  logic [7:0] baud_divisor, tx_write_data, rx_data_buffer, got, c;
  logic [7:0] tdat [5] = '{8'ha5, 8'h5a, 8'h81, 8'hc3, 8'h0f};
  logic [7:0] tcfg [5] = '{8'h00, 8'h05, 8'h06, 8'h59, 8'h87};
  int         n_errors = 0, checks = 0, cyc = 0, bt = 32, w, i;

  uart_rx_sampling_tx_rx_path u_uart_rx_sampling_tx_rx_path (.core_clk, .rst, .serial_rx_in,
    .serial_tx_out, .base_clock_sel, .oversample_sel, .baud_divisor, .rx_noise_filter_sel,
    .parity_enable, .parity_odd, .stop_bit_count, .infrared_mode_sel, .low_power_mode,
    .tx_enable_bit, .rx_enable_bit, .tx_write, .tx_write_data, .tx_buffer_full,
    .tx_interrupt_request, .rx_read, .rx_data_buffer, .rx_buffer_full, .rx_interrupt_request,
    .rx_overrun);
  remote_node u_remote_node (.core_clk(core_clk), .line_out(serial_rx_in),
    .line_in(serial_tx_out));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      finish_test();
    end
  end

  task automatic check(input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("BAD at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic wr(input logic [7:0] d);
    tx_write = 1'b1;
    tx_write_data = d;
    @(negedge core_clk);
    tx_write = 1'b0;
  endtask

  task automatic get_tx(input logic [7:0] d);
    u_remote_node.recv(bt, parity_enable, stop_bit_count + 1, got, gp, gs, w);
    check(got, d);
    if (parity_enable) check(gp, ^d ^ parity_odd);
    check(gs, 1'b1);
  endtask

  task automatic rd();
    rx_read = 1'b1;
    @(negedge core_clk);
    rx_read = 1'b0;
    check(rx_buffer_full, 1'b0);
  endtask

  task automatic rx_frame(input logic [7:0] d, input int sl, input logic [7:0] eb, input logic ov);
    fork
      u_remote_node.send(d, bt, sl, parity_enable);
      begin
        for (w = 0; w < 3000 && rx_interrupt_request !== 1'b1 && rx_overrun !== 1'b1; w++)
          @(negedge core_clk);
        check({rx_overrun, rx_interrupt_request, rx_buffer_full, rx_data_buffer},
              {ov, ~ov, 1'b1, eb});
      end
    join
  endtask

  initial begin
    rst = 1'b1;
    {parity_enable, parity_odd, stop_bit_count, infrared_mode_sel, low_power_mode} = 5'h00;
    {tx_enable_bit, rx_enable_bit, tx_write, rx_read} = 4'h0;
    {base_clock_sel, oversample_sel, rx_noise_filter_sel} = 7'h00;
    baud_divisor = 8'h01;
    tx_write_data = 8'h00;
    repeat (12) @(negedge core_clk);
    rst = 1'b0;
    check({serial_tx_out, tx_buffer_full, tx_interrupt_request, rx_buffer_full, rx_data_buffer},
          {4'h8, 8'h00});
    $display("reset test done");
    // Words written while the line is parked must not load; the later one wins.
    tx_enable_bit = 1'b1;
    low_power_mode = 1'b1;
    infrared_mode_sel = 1'b1;
    wr(8'h11);
    @(negedge core_clk);
    wr(8'h3c);
    repeat (3) @(negedge core_clk);
    check({tx_buffer_full, serial_tx_out}, 2'b10);
    low_power_mode = 1'b0;
    infrared_mode_sel = 1'b0;
    @(negedge core_clk);
    get_tx(8'h3c);
    repeat (bt) @(negedge core_clk);
    $display("overwrite test done");
    for (i = 0; i < 5; i++) begin
      c = tcfg[i];
      {base_clock_sel, oversample_sel, parity_enable, parity_odd, stop_bit_count} = c;
      bt = (16 - c[5:3]) * 2 * (1 << c[7:6]);
      check(tx_buffer_full, 1'b0);
      wr(tdat[i]);
      check(tx_buffer_full, 1'b1);
      @(negedge core_clk);
      check({tx_buffer_full, tx_interrupt_request}, 2'b01);
      wr(~tdat[i]);
      get_tx(tdat[i]);
      get_tx(~tdat[i]);
      check(w < bt, 1'b1);
      repeat (bt) @(negedge core_clk);
    end
    $display("transmit test done");
    {base_clock_sel, oversample_sel, stop_bit_count} = 6'h00;
    parity_enable = 1'b1;
    bt = 32;
    rx_enable_bit = 1'b1;
    rx_frame(8'h5a, bt, 8'h5a, 1'b0);
    rx_frame(8'hc3, bt, 8'h5a, 1'b1);
    rd();
    rx_frame(8'h3d, bt / 4, 8'h3d, 1'b0);
    rd();
    // Slower base clock, 13 oversamples and two stop bits give a 52-cycle bit.
    {base_clock_sel, oversample_sel, stop_bit_count} = 6'h17;
    bt = 52;
    rx_frame(8'hb4, bt, 8'hb4, 1'b0);
    {base_clock_sel, oversample_sel, stop_bit_count} = 6'h00;
    bt = 32;
    $display("receive test done");
    for (i = 1; i < 4; i++) begin
      rd();
      rx_noise_filter_sel = i[1:0];
      seen = 1'b0;
      u_remote_node.pulse((1 << (i - 1)) * 2 - 1);
      repeat (12 * bt) begin
        @(negedge core_clk);
        seen |= rx_interrupt_request;
      end
      check(seen, 1'b0);
      rx_frame(8'h96 ^ i[7:0], bt, 8'h96 ^ i[7:0], 1'b0);
    end
    $display("filter test done");
    finish_test();
  end
endmodule
